// file: design/ofd_decoder.sv
// Opcode field decoder for processor control and common operand fields
// What this block does
// - Bytes FA, FB and FD decode as mask, unmask interrupts and set direction, no operands.
// - Byte F0 is a bus lock prefix that raises lock for the following instruction.
// - A first byte 11011xxx is an external device escape whose middle operand bits are ignored.
// - Direction bit 1 makes the register the destination, 0 the source.
// - Width bit 1 selects word operation, 0 byte operation.
// - Sign and width both 1 sign-extend one immediate byte and fetch no second one.
// - Count bit 0 gives a shift count of one, 1 takes it from the count register low byte.
// - The repeat compare bit is matched with the zero flag to continue a string compare.
// - A byte 001ss110 is a segment override prefix for the next memory operand.
// - Addressing form 11 makes the operand locator a register selector.
// - Addressing form 00 gives zero displacement except for the direct address.
// - Register 000 is the wide or narrow accumulator, segment code 00 the extra segment.
// - Above and below use unsigned results, greater and less use signed ones.
// - Addressing form 01 sign-extends one displacement byte to 16 bits.
// - Locator 000 in memory form addresses base plus source index plus displacement.
`default_nettype none
module ofd_decoder (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // Instruction bytes from prefetch
  input  wire logic        instValid,
  input  wire logic [7:0]  opByte,
  input  wire logic [7:0]  modeByte,
  input  wire logic [7:0]  dispLow,
  input  wire logic [7:0]  dispHigh,
  input  wire logic [7:0]  immLow,
  input  wire logic [7:0]  immHigh,
  // Flags and count register from datapath
  input  wire logic        zeroFlag,
  input  wire logic        carryFlag,
  input  wire logic        signFlag,
  input  wire logic        overflowFlag,
  input  wire logic [7:0]  shiftCountByte,
  input  wire logic [1:0]  condSelect,
  // Processor control decodes
  output logic             maskInterruptsOp,
  output logic             unmaskInterruptsOp,
  output logic             setDirectionOp,
  output logic             externalDeviceOpcode,
  output logic             isPrefix,
  output logic             busLock,
  output logic             segOverride,
  output logic [1:0]       segSelect,
  // Common fields
  output logic             decodeValid,
  output logic             regIsDest,
  output logic             wordOp,
  output logic [15:0]      immOperand,
  output logic [1:0]       immBytes,
  output logic [4:0]       shiftCount,
  output logic             repeatContinue,
  output logic             locIsRegister,
  output logic [2:0]       regSelect,
  output logic             regIsAccumulator,
  output logic [1:0]       dispBytes,
  output logic [15:0]      displacement,
  output logic             eaBasePlusSource,
  output logic             condTrue
);
  // ****************************************
  // Reset synchroniser
  // ****************************************
  logic rstMeta_q;
  logic rstSync_q;

  // Two-stage release of the reset
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rstMeta_q <= 1'b0;
      rstSync_q <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSync_q <= rstMeta_q;
    end
  end

  // ****************************************
  // Opcode classification
  // ****************************************
  wire logic opMask    = (opByte == ofd_pkg::OP_MASK_INTERRUPTS);
  wire logic opUnmask  = (opByte == ofd_pkg::OP_UNMASK_INTERRUPTS);
  wire logic opSetDir  = (opByte == ofd_pkg::OP_SET_DIRECTION);
  wire logic opLock    = (opByte == ofd_pkg::OP_BUS_LOCK);
  wire logic opEscape  = (opByte[7:3] == ofd_pkg::OP_EXTERNAL_DEV_HI);
  wire logic opSegOvr  = (opByte[7:5] == ofd_pkg::OP_SEG_OVR_HI) &&
                         (opByte[2:0] == ofd_pkg::OP_SEG_OVR_LO);
  wire logic opRepeat  = (opByte[7:1] == ofd_pkg::OP_REPEAT_HI);
  wire logic prefixIn  = opLock || opSegOvr || opRepeat;
  wire logic takeInst  = instValid && !prefixIn;
  wire logic takePrefix = instValid && prefixIn;

  // Held prefix state, read by the field decode below
  logic       lockPending_q;
  logic       segPending_q;
  logic [1:0] segCode_q;
  logic       repPending_q;
  logic       repCmp_q;

  // ****************************************
  // Common field decode
  // ****************************************
  wire logic       wBit    = opByte[ofd_pkg::WIDTH_BIT];
  wire logic       dBit    = opByte[ofd_pkg::DIR_BIT];
  wire logic       sBit    = opByte[ofd_pkg::SIGN_BIT];
  wire logic       vBit    = opByte[ofd_pkg::COUNT_BIT];
  wire logic       signExt = sBit && wBit;
  wire logic [2:0] regFld  = modeByte[ofd_pkg::REG_LSB +: 3];
  wire logic [2:0] locFld  = modeByte[ofd_pkg::LOC_LSB +: 3];

  // Immediate operand forming
  wire logic [15:0] immNext = signExt ? {{8{immLow[7]}}, immLow} :
                              wBit    ? {immHigh, immLow} : {8'h00, immLow};
  wire logic [1:0]  immLen  = (wBit && !signExt) ? 2'h2 : 2'h1;

  // Shift count source, count masked to five bits
  wire logic [4:0] countNext = vBit ? shiftCountByte[4:0] : ofd_pkg::COUNT_ONE;

  // Repeat continues while zero flag matches the held compare bit
  wire logic repNext = repPending_q && (zeroFlag == repCmp_q);

  // Escape ignores middle bits, register form uses locator as selector
  wire logic       regForm;
  wire logic [2:0] regNext = opEscape ? locFld :
                             regForm  ? locFld : regFld;

  // Unsigned and signed comparison conditions
  wire logic below   = carryFlag;
  wire logic belEq   = carryFlag || zeroFlag;
  wire logic less    = signFlag ^ overflowFlag;
  wire logic lessEq  = less || zeroFlag;
  wire logic condNext = (condSelect == ofd_pkg::COND_BELOW)  ? below :
                        (condSelect == ofd_pkg::COND_BEL_EQ) ? belEq :
                        (condSelect == ofd_pkg::COND_LESS)   ? less  : lessEq;

  // ****************************************
  // Addressing byte decode
  // ****************************************
  wire logic        directAddr;
  wire logic [1:0]  dispLen;
  wire logic [15:0] dispVal;
  wire logic        eaBps;

  ofd_operand_fields uFields (
    .modeByte         (modeByte),
    .dispLow          (dispLow),
    .dispHigh         (dispHigh),
    .locIsRegister    (regForm),
    .directAddress    (directAddr),
    .dispBytes        (dispLen),
    .displacement     (dispVal),
    .eaBasePlusSource (eaBps)
  );

  // ****************************************
  // Next values
  // ****************************************
  // Held prefix codes load only from a new prefix of their own kind; a taken instruction returns them to reset values
  wire logic [1:0] segCodeNext = opSegOvr ? opByte[ofd_pkg::SEG_LSB +: 2] :
                                 segCode_q;
  wire logic       repCmpNext  = opRepeat ? opByte[ofd_pkg::CMP_BIT] : repCmp_q;

  // Processor control pulses for a taken instruction
  wire logic maskNext   = takeInst && opMask;
  wire logic unmaskNext = takeInst && opUnmask;
  wire logic setDirNext = takeInst && opSetDir;
  wire logic escapeNext = takeInst && opEscape;
  wire logic lockNext   = takeInst && lockPending_q;
  wire logic segOvrNext = takeInst && segPending_q;

  // Register form and displacement as loaded
  wire logic        locRegNext  = regForm || opEscape;
  wire logic        accumNext   = (regNext == ofd_pkg::REG_ACCUM);
  wire logic [1:0]  dispLenNext = regForm ? 2'h0 : dispLen;
  wire logic [15:0] dispValNext = regForm ? 16'h0000 : dispVal;

  // ****************************************
  // Prefix hold
  // ****************************************
  // Lock prefix waits for the next instruction
  always_ff @(posedge mclk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      lockPending_q <= 1'b0;
    end else if (takePrefix) begin
      lockPending_q <= lockPending_q || opLock;
    end else if (takeInst) begin
      lockPending_q <= 1'b0;
    end
  end

  // Segment override code waits for the next instruction
  always_ff @(posedge mclk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      segPending_q <= 1'b0;
      segCode_q    <= ofd_pkg::SEG_DATA;
    end else if (takePrefix) begin
      segPending_q <= segPending_q || opSegOvr;
      segCode_q    <= segCodeNext;
    end else if (takeInst) begin
      segPending_q <= 1'b0;
      segCode_q    <= ofd_pkg::SEG_DATA;
    end
  end

  // Repeat compare sense waits for the next instruction
  always_ff @(posedge mclk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      repPending_q <= 1'b0;
      repCmp_q     <= 1'b0;
    end else if (takePrefix) begin
      repPending_q <= repPending_q || opRepeat;
      repCmp_q     <= repCmpNext;
    end else if (takeInst) begin
      repPending_q <= 1'b0;
      repCmp_q     <= 1'b0;
    end
  end

  // ****************************************
  // Output registers
  // ****************************************
  // Interrupt, direction and escape pulses
  always_ff @(posedge mclk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      maskInterruptsOp     <= 1'b0;
      unmaskInterruptsOp   <= 1'b0;
      setDirectionOp       <= 1'b0;
      externalDeviceOpcode <= 1'b0;
    end else begin
      maskInterruptsOp     <= maskNext;
      unmaskInterruptsOp   <= unmaskNext;
      setDirectionOp       <= setDirNext;
      externalDeviceOpcode <= escapeNext;
    end
  end

  // Prefix results and instruction strobe
  always_ff @(posedge mclk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      isPrefix    <= 1'b0;
      busLock     <= 1'b0;
      segOverride <= 1'b0;
      segSelect   <= ofd_pkg::SEG_DATA;
      decodeValid <= 1'b0;
    end else begin
      isPrefix    <= takePrefix;
      busLock     <= lockNext;
      segOverride <= segOvrNext;
      segSelect   <= segCode_q;
      decodeValid <= takeInst;
    end
  end

  // Direction, width and immediate operand of each instruction
  always_ff @(posedge mclk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      regIsDest  <= 1'b0;
      wordOp     <= 1'b0;
      immOperand <= 16'h0000;
      immBytes   <= 2'h0;
    end else if (takeInst) begin
      regIsDest  <= dBit;
      wordOp     <= wBit;
      immOperand <= immNext;
      immBytes   <= immLen;
    end
  end

  // Shift count, repeat decision and condition
  always_ff @(posedge mclk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      shiftCount     <= ofd_pkg::COUNT_ONE;
      repeatContinue <= 1'b0;
      condTrue       <= 1'b0;
    end else if (takeInst) begin
      shiftCount     <= countNext;
      repeatContinue <= repNext;
      condTrue       <= condNext;
    end
  end

  // Register selection and addressing form
  always_ff @(posedge mclk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      locIsRegister    <= 1'b0;
      regSelect        <= ofd_pkg::REG_ACCUM;
      regIsAccumulator <= 1'b0;
      dispBytes        <= 2'h0;
      displacement     <= 16'h0000;
      eaBasePlusSource <= 1'b0;
    end else if (takeInst) begin
      locIsRegister    <= locRegNext;
      regSelect        <= regNext;
      regIsAccumulator <= accumNext;
      dispBytes        <= dispLenNext;
      displacement     <= dispValNext;
      eaBasePlusSource <= eaBps;
    end
  end
endmodule
`default_nettype wire

// file: design/ofd_pkg.sv
// Constants shared by the opcode field decoder
`default_nettype none
package ofd_pkg;
  // ****************************************
  // Opcode values
  // ****************************************
  localparam logic [7:0] OP_MASK_INTERRUPTS   = 8'hFA;
  localparam logic [7:0] OP_UNMASK_INTERRUPTS = 8'hFB;
  localparam logic [7:0] OP_SET_DIRECTION     = 8'hFD;
  localparam logic [7:0] OP_BUS_LOCK          = 8'hF0;
  localparam logic [4:0] OP_EXTERNAL_DEV_HI   = 5'h1B;
  localparam logic [2:0] OP_SEG_OVR_HI        = 3'h1;
  localparam logic [2:0] OP_SEG_OVR_LO        = 3'h6;
  localparam logic [6:0] OP_REPEAT_HI         = 7'h79;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int unsigned WIDTH_BIT   = 0;
  localparam int unsigned DIR_BIT     = 1;
  localparam int unsigned SIGN_BIT    = 1;
  localparam int unsigned COUNT_BIT   = 1;
  localparam int unsigned CMP_BIT     = 0;
  localparam int unsigned SEG_LSB     = 3;
  localparam int unsigned MODE_LSB    = 6;
  localparam int unsigned REG_LSB     = 3;
  localparam int unsigned LOC_LSB     = 0;
  // ****************************************
  // Field values and reset values
  // ****************************************
  localparam logic [1:0] MODE_NO_DISP   = 2'h0;
  localparam logic [1:0] MODE_DISP8     = 2'h1;
  localparam logic [1:0] MODE_DISP16    = 2'h2;
  localparam logic [1:0] MODE_REGISTER  = 2'h3;
  localparam logic [2:0] LOC_DIRECT     = 3'h6;
  localparam logic [2:0] LOC_BASE_SRC   = 3'h0;
  localparam logic [2:0] REG_ACCUM      = 3'h0;
  localparam logic [1:0] SEG_EXTRA      = 2'h0;
  localparam logic [1:0] SEG_DATA       = 2'h3;
  localparam logic [4:0] COUNT_ONE      = 5'h01;
  localparam logic [7:0] RESET_BYTE     = 8'h00;
  // Condition selector codes
  localparam logic [1:0] COND_BELOW     = 2'h0;
  localparam logic [1:0] COND_BEL_EQ    = 2'h1;
  localparam logic [1:0] COND_LESS      = 2'h2;
  localparam logic [1:0] COND_LESS_EQ   = 2'h3;
endpackage
`default_nettype wire

// file: design/ofd_operand_fields.sv
// Combinational decode of the addressing byte and its displacement
`default_nettype none
module ofd_operand_fields (
  // Addressing byte and displacement
  input  wire logic [7:0]  modeByte,
  input  wire logic [7:0]  dispLow,
  input  wire logic [7:0]  dispHigh,
  // Decoded fields
  output logic             locIsRegister,
  output logic             directAddress,
  output logic [1:0]       dispBytes,
  output logic [15:0]      displacement,
  output logic             eaBasePlusSource
);
  // ****************************************
  // Field split
  // ****************************************
  wire logic [1:0] mode = modeByte[ofd_pkg::MODE_LSB +: 2];
  wire logic [2:0] loc  = modeByte[ofd_pkg::LOC_LSB +: 3];

  // Register form and direct address exception
  assign locIsRegister = (mode == ofd_pkg::MODE_REGISTER);
  assign directAddress = (mode == ofd_pkg::MODE_NO_DISP) && (loc == ofd_pkg::LOC_DIRECT);

  // Displacement length and value
  assign dispBytes = directAddress                     ? 2'h2 :
                     (mode == ofd_pkg::MODE_DISP8)     ? 2'h1 :
                     (mode == ofd_pkg::MODE_DISP16)    ? 2'h2 : 2'h0;
  assign displacement = (directAddress || mode == ofd_pkg::MODE_DISP16) ? {dispHigh, dispLow} :
                        (mode == ofd_pkg::MODE_DISP8) ? {{8{dispLow[7]}}, dispLow} :
                        16'h0000;
  // Base plus source index form
  assign eaBasePlusSource = !locIsRegister && (loc == ofd_pkg::LOC_BASE_SRC);
endmodule
`default_nettype wire

// file: verification/ofd_decoder_checker.sv
// Concurrent checks on the opcode field decoder ports
`default_nettype none
module ofd_decoder_checker (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rstn,
  // Instruction bytes
  input wire logic        instValid,
  input wire logic [7:0]  opByte,
  input wire logic [7:0]  modeByte,
  input wire logic [7:0]  dispLow,
  // Decoder outputs
  input wire logic        maskInterruptsOp,
  input wire logic        unmaskInterruptsOp,
  input wire logic        setDirectionOp,
  input wire logic        externalDeviceOpcode,
  input wire logic        isPrefix,
  input wire logic        busLock,
  input wire logic        decodeValid,
  input wire logic        locIsRegister,
  input wire logic [1:0]  dispBytes,
  input wire logic [15:0] displacement
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // Prefix byte recognition and non-prefix take
  wire logic pre = opByte == ofd_pkg::OP_BUS_LOCK || opByte[7:1] == ofd_pkg::OP_REPEAT_HI
    || (opByte[7:5] == ofd_pkg::OP_SEG_OVR_HI && opByte[2:0] == ofd_pkg::OP_SEG_OVR_LO);
  wire logic nonPre = instValid && !pre;
  wire logic [1:0] md = modeByte[7:6];
  sequence lockThenOp;
    instValid && opByte == ofd_pkg::OP_BUS_LOCK ##1 nonPre;
  endsequence
  mask_op_a: assert property (
    instValid && opByte == 8'hFA |=> maskInterruptsOp && decodeValid)
    else $error("mask decode missing");
  unmask_op_a: assert property (
    instValid && opByte == 8'hFB |=> unmaskInterruptsOp)
    else $error("unmask decode missing");
  set_dir_a: assert property (
    instValid && opByte == 8'hFD |=> setDirectionOp && !maskInterruptsOp && !unmaskInterruptsOp)
    else $error("set direction decode missing");
  escape_op_a: assert property (
    instValid && opByte[7:3] == 5'h1B |=> externalDeviceOpcode)
    else $error("escape decode missing");
  lock_next_a: assert property (
    lockThenOp |=> busLock && decodeValid)
    else $error("lock not applied to next instruction");
  prefix_only_a: assert property (
    instValid && pre |=> isPrefix && !decodeValid)
    else $error("prefix produced a decode");
  lock_with_op_a: assert property (
    busLock |-> decodeValid && $past(instValid))
    else $error("lock outside an instruction");
  reg_form_a: assert property (
    nonPre && md == 2'h3 |=> locIsRegister && dispBytes == 2'h0)
    else $error("register form misdecoded");
  disp8_a: assert property (
    nonPre && md == 2'h1 |=> dispBytes == 2'h1
    && displacement == {{8{$past(dispLow[7])}}, $past(dispLow)})
    else $error("short displacement wrong");
  no_disp_a: assert property (
    nonPre && md == 2'h0 && modeByte[2:0] != 3'h6
    |=> dispBytes == 2'h0 && displacement == 16'h0000)
    else $error("zero displacement wrong");
endmodule
bind ofd_decoder ofd_decoder_checker chk_u (.*);
`default_nettype wire

// file: verification/ofd_prefetch_model.sv
// Prefetch queue and datapath model feeding the decoder
`default_nettype none
module ofd_prefetch_model (
  // Clock
  input  wire logic        mclk,
  // Instruction bytes
  output logic             instValid,
  output logic [7:0]       opByte,
  output logic [7:0]       modeByte,
  output logic [7:0]       dispLow,
  output logic [7:0]       dispHigh,
  output logic [7:0]       immLow,
  output logic [7:0]       immHigh,
  // Flags and count register
  output logic             zeroFlag,
  output logic             carryFlag,
  output logic             signFlag,
  output logic             overflowFlag,
  output logic [7:0]       shiftCountByte,
  output logic [1:0]       condSelect
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle state at time zero
  initial begin
    {instValid, opByte, modeByte, dispLow, dispHigh, immLow, immHigh} = '0;
    {zeroFlag, carryFlag, signFlag, overflowFlag, shiftCountByte, condSelect} = '0;
  end
  // One byte group held across its taking edge; released bytes show stale inverse
  task automatic send(input logic [7:0] op, md, input logic [15:0] d, im, input bit hold);
    // Idle cycle after a release, so valid never falls and rises in one step
    if (!instValid) begin
      @(posedge mclk);
      #1;
    end
    instValid = 1'b1;
    {opByte, modeByte, dispHigh, dispLow, immHigh, immLow} = {op, md, d, im};
    @(posedge mclk);
    #1;
    if (!hold) begin
      instValid = 1'b0;
      {opByte, modeByte, dispHigh, dispLow, immHigh, immLow} = ~{op, md, d, im};
    end
  endtask
endmodule
`default_nettype wire

// file: verification/ofd_decoder_tb.sv
// Self-checking bench for the opcode field decoder
`default_nettype none
module ofd_decoder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  int n_mismatch = 0;
  int checked = 0;
  int cyc = 0;
  wire logic instValid, zeroFlag, carryFlag, signFlag, overflowFlag;
  wire logic [7:0] opByte, modeByte, dispLow, dispHigh, immLow, immHigh, shiftCountByte;
  wire logic [1:0] condSelect, segSelect, immBytes, dispBytes;
  wire logic maskInterruptsOp, unmaskInterruptsOp, setDirectionOp, externalDeviceOpcode;
  wire logic isPrefix, busLock, segOverride, decodeValid, regIsDest, wordOp, repeatContinue;
  wire logic locIsRegister, regIsAccumulator, eaBasePlusSource, condTrue;
  wire logic [15:0] immOperand, displacement;
  wire logic [4:0] shiftCount;
  wire logic [2:0] regSelect;
  ofd_decoder dut_u (.*);
  ofd_prefetch_model pf_u (.*);
  // Clock and hang guard
  initial forever #4 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  task automatic chk(input string nm, input logic [17:0] got, exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic sd(input logic [7:0] op, md, input logic [15:0] d, im, input bit hold);
    pf_u.send(op, md, d, im, hold);
  endtask
  // Control opcodes, one pulse each
  task automatic t_ctrl();
    logic [7:0] ops [3] = '{8'hFA, 8'hFB, 8'hFD};
    foreach (ops[i]) begin
      sd(ops[i], 8'h00, 16'h0, 16'h0, 0);
      chk("ctrl", {setDirectionOp, unmaskInterruptsOp, maskInterruptsOp}, 16'(3'h1 << i));
      chk("ctrlLock", {decodeValid, busLock}, 2'h2);
    end
  endtask
  // Lock and segment prefixes back to back, then cleared
  task automatic t_prefix();
    sd(8'hF0, 8'h00, 16'h0, 16'h0, 1);
    chk("lockPre", {isPrefix, decodeValid, busLock}, 3'h4);
    sd(8'h26, 8'h00, 16'h0, 16'h0, 1);
    chk("segPre", {isPrefix, decodeValid}, 2'h2);
    sd(8'hFA, 8'h00, 16'h0, 16'h0, 1);
    chk("applied", {busLock, segOverride, segSelect, maskInterruptsOp}, 5'h19);
    sd(8'h8B, 8'h00, 16'h0, 16'h0, 0);
    chk("cleared", {busLock, segOverride, segSelect}, 4'h3);
    sd(8'hF0, 8'h00, 16'h0, 16'h0, 1);
    sd(8'hFD, 8'h00, 16'h0, 16'h0, 0);
    chk("lockDir", {busLock, segOverride, setDirectionOp}, 3'h5);
  endtask
  // Direction, width, addressing form and displacement
  task automatic t_fields();
    sd(8'h8B, 8'hC0, 16'h0, 16'h0, 1);
    chk("regForm", {regIsDest, wordOp, locIsRegister, regIsAccumulator}, 4'hF);
    sd(8'h88, 8'h46, 16'h1280, 16'h0, 1);
    chk("byteForm", {regIsDest, wordOp, regIsAccumulator, dispBytes}, 5'h05);
    chk("disp8", displacement, 16'hFF80);
    sd(8'h8B, 8'h00, 16'h1255, 16'h0, 1);
    chk("noDisp", {dispBytes, eaBasePlusSource}, 3'h1);
    chk("dispZero", displacement, 16'h0000);
    sd(8'h8B, 8'h06, 16'h1234, 16'h0, 0);
    chk("direct", {dispBytes, displacement}, 18'h21234);
  endtask
  // Immediate width, shift count source, escape locator
  task automatic t_imm_shift();
    sd(8'h83, 8'hC0, 16'h0, 16'h12F0, 1);
    chk("immSext", {immBytes, immOperand}, 18'h1FFF0);
    sd(8'h81, 8'hC0, 16'h0, 16'h12F0, 1);
    chk("immWord", {immBytes, immOperand}, 18'h212F0);
    pf_u.shiftCountByte = 8'h27;
    sd(8'hD1, 8'hE0, 16'h0, 16'h0, 1);
    chk("countOne", 16'(shiftCount), 16'h1);
    sd(8'hD3, 8'hE0, 16'h0, 16'h0, 1);
    chk("countReg", 16'(shiftCount), 16'h7);
    sd(8'hDF, 8'h3D, 16'h0, 16'h0, 0);
    chk("escape", {externalDeviceOpcode, regSelect}, 4'hD);
  endtask
  // Repeat compare sense against zero flag, and condition evaluation
  task automatic t_rep_cond();
    logic [5:0] tbl [6] = '{6'b00_100_1, 6'b00_011_0, 6'b01_000_1,
                            6'b10_010_1, 6'b10_111_0, 6'b11_000_1};
    for (int i = 0; i < 4; i++) begin
      pf_u.zeroFlag = i[0];
      sd({7'h79, i[1]}, 8'h00, 16'h0, 16'h0, 1);
      sd(8'hA6, 8'h00, 16'h0, 16'h0, 0);
      chk("repeat", repeatContinue, i[0] == i[1]);
    end
    pf_u.zeroFlag = 1'b1;
    foreach (tbl[i]) begin
      {pf_u.condSelect, pf_u.carryFlag, pf_u.signFlag, pf_u.overflowFlag} = tbl[i][5:1];
      sd(8'h90, 8'h00, 16'h0, 16'h0, 0);
      chk("cond", condTrue, tbl[i][0]);
    end
  endtask
  task automatic wrap_up();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Reset, then scenarios
  initial begin
    repeat (10) @(posedge mclk);
    #1 rstn = 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    t_ctrl();
    t_prefix();
    t_fields();
    t_imm_shift();
    t_rep_cond();
    wrap_up();
  end
endmodule
`default_nettype wire
